// ===== tb/adc_input_mux_pga_control_tb_top.sv
// Self-checking bench for the front-end control block
`timescale 1ns/1ps
`default_nettype none
module adc_input_mux_pga_control_tb_top
   import afe_pkg::*;
;
   typedef struct packed {logic brk; logic [38:0] snap;} afe_note_t;
   logic        clk, rst, sclk, cs_n, din, dout, dout_oe_n;
   logic [3:0]  rail_cmp;
   logic [12:0] pos_switch, neg_switch;
   logic        mid_short, temp_sense_en, avdd_mon_en, dvdd_mon_en;
   logic        burnout_en, amp_power_en, amp_bypass, amp_high_bias;
   logic [2:0]  analog_gain;
   logic [1:0]  digital_shift;
   logic [38:0] snap;
   logic [38:0] prev = '1;
   logic [38:0] cur = '1;
   logic [7:0]  rd, insel, gain, sysmon;
   logic [7:0]  rq[$];
   afe_note_t   q[$];
   afe_note_t   n;
   int          err_total = 0;
   int          checks_done = 0;
   int          brk_len = 0;
   logic        in_brk = 1'b0;
   event        rd_ev;
   logic [4:0]  offs [6] = '{ADDR_STATUS, ADDR_INSEL, ADDR_GAIN, ADDR_EXC1,
                             ADDR_SYSMON, 5'h1F};
   logic [7:0]  rvals [6] = '{RST_STATUS, RST_INSEL, RST_GAIN, RST_EXC1,
                              RST_SYSMON, 8'h00};

   // System clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   afe_front_end_ctrl #(.NIN(NUM_INPUTS)) DUT (
      .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout), .dout_oe_n(dout_oe_n), .rail_cmp(rail_cmp),
      .pos_switch(pos_switch), .neg_switch(neg_switch),
      .mid_short(mid_short), .temp_sense_en(temp_sense_en),
      .avdd_mon_en(avdd_mon_en), .dvdd_mon_en(dvdd_mon_en),
      .burnout_en(burnout_en), .amp_power_en(amp_power_en),
      .amp_bypass(amp_bypass), .analog_gain(analog_gain),
      .digital_shift(digital_shift), .amp_high_bias(amp_high_bias));

   afe_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
                        .dout_oe_n(dout_oe_n));

   // All front-end outputs as one word so any stray change is seen
   assign snap = {pos_switch, neg_switch, mid_short, temp_sense_en,
                  avdd_mon_en, dvdd_mon_en, burnout_en, amp_power_en,
                  amp_bypass, analog_gain, digital_shift, amp_high_bias};

   task automatic check(input string what, input logic [38:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Expected outputs from the register copies kept by the bench
   function automatic logic [38:0] model(input logic brk);
      logic [12:0] p, m_n;
      logic [2:0]  m, c;
      logic        on, hi;
      m = (brk || sysmon[2:0] > MON_DVDD) ? MON_NONE : sysmon[2:0];
      p = (brk || m != MON_NONE || insel[7:4] > CH_COMMON) ? 13'h0000
          : 13'h0001 << insel[7:4];
      m_n = (brk || m != MON_NONE || insel[3:0] > CH_COMMON) ? 13'h0000
            : 13'h0001 << insel[3:0];
      c = gain[2:0];
      on = (gain[4:3] != AMP_OFF) || (c != GAIN_CODE_1);
      hi = on && (c > GAIN_CODE_32);
      return {p, m_n, brk || m == MON_SHORT, m == MON_TEMP, m == MON_AVDD,
              m == MON_DVDD, sysmon[3] && m == MON_NONE && !brk, on, !on,
              on ? (hi ? GAIN_CODE_32 : c) : 3'h0,
              hi ? 2'(c - GAIN_CODE_32) : 2'h0, hi};
   endfunction : model

   task automatic note(input logic brk);
      if (model(brk) !== cur) begin
         cur = model(brk);
         q.push_back({brk, cur});
      end
   endtask : note

   // Register write; expected output changes are queued before the frame
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] junk;
      if (a == ADDR_INSEL && d != insel) begin
         insel = d;
         note(1'b1);
      end
      if (a == ADDR_GAIN) gain = d;
      if (a == ADDR_SYSMON) sysmon = d;
      note(1'b0);
      host.xfer({OP_WRITE, a}, d, junk);
      repeat (4) @(posedge clk);
   endtask : wr

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
      rq.push_back(e);
      host.xfer({OP_READ, a}, 8'h00, rd);
      -> rd_ev;
      repeat (2) @(posedge clk);
   endtask : rd_chk

   // Output watcher: every change must match the oldest queued note
   always @(posedge clk) begin
      if (!rst && snap !== prev) begin
         if (in_brk) check("break", brk_len, BBM_CYCLES);
         n = (q.size() > 0) ? q.pop_front() : afe_note_t'({1'b0, prev});
         check("switch", snap[38:13], n.snap[38:13]);
         check("monitor", snap[12:8], n.snap[12:8]);
         check("power", snap[7:6], n.snap[7:6]);
         check("gain", snap[5:0], n.snap[5:0]);
         in_brk = n.brk;
         brk_len = 0;
         prev = snap;
      end
      brk_len++;
   end

   // Read watcher: each completed read frame against its note
   always @(rd_ev) begin
      check("read", rd, rq.pop_front());
   end

   task automatic stop_test;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   // Main sequence
   initial begin
      void'($urandom(32'h9608));
      rst <= 1'b1;
      rail_cmp <= 4'h0;
      insel = RST_INSEL;
      gain = RST_GAIN;
      sysmon = RST_SYSMON;
      note(1'b0);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      foreach (offs[i]) rd_chk(offs[i], rvals[i]);
      wr(5'h1F, 8'h5A);
      wr(ADDR_STATUS, 8'hFF);
      rd_chk(5'h1F, 8'h00);
      rd_chk(ADDR_STATUS, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         wr(ADDR_INSEL, {4'(i), 4'($urandom_range(15))});
         rd_chk(ADDR_INSEL, insel);
      end
      wr(ADDR_INSEL, {4'h3, CH_COMMON});
      rd_chk(ADDR_INSEL, insel);
      wr(ADDR_INSEL, insel); // Same value must not start a break
      $display("test channels done");
      for (int i = 0; i < 16; i++) begin
         wr(ADDR_GAIN, {3'h0, 1'b0, i[3], 3'(i)});
         rd_chk(ADDR_GAIN, gain);
      end
      $display("test gain done");
      for (int i = 0; i < 10; i++) wr(ADDR_SYSMON, 8'(i % 5 + (i / 5) * 8));
      $display("test monitors done");
      wr(ADDR_EXC1, 8'h80);
      repeat (4) begin
         rail_cmp <= 4'($urandom_range(15));
         repeat (4) @(posedge clk);
         rd_chk(ADDR_STATUS, {2'b00, rail_cmp, 2'b00});
      end
      rail_cmp <= 4'hF;
      wr(ADDR_EXC1, 8'h00);
      rd_chk(ADDR_STATUS, 8'h00);
      $display("test rail flags done");
      check("pending", 39'(q.size()), 39'h0);
      stop_test();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #1000000;
      err_total++;
      stop_test();
   end
endmodule : adc_input_mux_pga_control_tb_top
`default_nettype wire

// ===== tb/afe_host_model.sv
// Host serial master model that configures the front-end control
`timescale 1ns/1ps
`default_nettype none
module afe_host_model
   import afe_pkg::*;
(
   output logic      sclk,
   output logic      cs_n,
   output logic      din,
   input  wire logic dout,
   input  wire logic dout_oe_n
);
   // Link idles with the clock parked low and the frame deselected
   initial begin
      sclk = 1'b0;
      cs_n = 1'b0;
      din  = 1'b0;
      #5;
      cs_n = 1'b1; // A real rising edge clears the link counters
   end

   // One command byte and one data byte, MSB first; clock runs in frame only
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
                       output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, dat};
      if (cmd == {OP_WRITE, ADDR_GAIN}) sh[4] = 1'b0;
      rd = 8'h00;
      #7; // Leave the system clock edge at which the caller resumed
      cs_n = 1'b0;
      #210; // Read bank freezes before the first edge
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b1;
         din  = sh[i];
         #16;
         sclk = 1'b0;
         // An undriven output reads as unknown, so a late enable shows up
         if (i < 8) rd = {rd[6:0], dout_oe_n ? 1'bx : dout};
         #16;
      end
      cs_n = 1'b1;
      din  = ~din; // Released line must not look like held data
      #310; // Deselect gap before any further frame
   endtask : xfer
endmodule : afe_host_model
`default_nettype wire

// ===== verilog/afe_front_end_ctrl.sv
// Input mux, monitor and gain amplifier control with its register bank
//
// Operation
// - Independent positive and negative input channel fields
// - Common input selectable like any channel
// - Offset monitor shorts inputs at mid-supply
// - Supply monitors: analog and digital quarter
// - Temperature sensor monitor selection
// - Burn-out sources on selected inputs
// - Channel change: mid-supply two clocks first
// - Eight gains from 1 to 128
// - Enable field 00 bypasses at gain 1, 01 enables
// - Gains 64, 128: analog 32, digital rest
// - Rail flags show outputs near supplies
// - Rail detection runs only when enabled
// - Bypass allowed only at gain 1
// - Registers written and read over serial link
// - System clock times break-before-make interval
`timescale 1ns/1ps
`default_nettype none
module afe_front_end_ctrl
   import afe_pkg::*;
#(
   parameter int NIN = NUM_INPUTS
)(
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire logic           sclk,
   input  wire logic           cs_n,
   input  wire logic           din,
   output logic                dout,
   output logic                dout_oe_n,
   input  wire logic [3:0]     rail_cmp,
   output logic [NIN-1:0]      pos_switch,
   output logic [NIN-1:0]      neg_switch,
   output logic                mid_short,
   output logic                temp_sense_en,
   output logic                avdd_mon_en,
   output logic                dvdd_mon_en,
   output logic                burnout_en,
   output logic                amp_power_en,
   output logic                amp_bypass,
   output logic [2:0]          analog_gain,
   output logic [1:0]          digital_shift,
   output logic                amp_high_bias
);
   // Channel code to one-hot switch enables; unused codes open all
   function automatic logic [NIN-1:0] chan_onehot(input logic [3:0] code);
      logic [NIN-1:0] v;
      v = '0;
      if (int'(code) < NIN) begin
         v[code] = 1'b1;
      end
      return v;
   endfunction : chan_onehot

   logic       wr_valid;
   logic [4:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] sh_status_r, sh_insel_r, sh_gain_r, sh_exc1_r, sh_sysmon_r;

   afe_spi_link u_link (
      .sclk      (sclk),
      .cs_n      (cs_n),
      .din       (din),
      .dout      (dout),
      .dout_oe_n (dout_oe_n),
      .rd_status (sh_status_r),
      .rd_insel  (sh_insel_r),
      .rd_gain   (sh_gain_r),
      .rd_exc1   (sh_exc1_r),
      .rd_sysmon (sh_sysmon_r),
      .wr_valid  (wr_valid),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data)
   );

   // Synchronisers for the frame select and the rail comparators
   logic       cs_s1_r, cs_s2_r, cs_s3_r;
   logic [3:0] rail_s1_r, rail_s2_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         cs_s1_r   <= 1'b1;
         cs_s2_r   <= 1'b1;
         cs_s3_r   <= 1'b1;
         rail_s1_r <= 4'h0;
         rail_s2_r <= 4'h0;
      end else begin
         cs_s1_r   <= cs_n;
         cs_s2_r   <= cs_s1_r;
         cs_s3_r   <= cs_s2_r;
         rail_s1_r <= rail_cmp;
         rail_s2_r <= rail_s1_r;
      end
   end

   // Write words are stable by the time the frame end is seen here
   logic commit;
   assign commit = cs_s2_r & ~cs_s3_r & wr_valid;

   // Register bank and mux sequencing state
   logic [7:0] insel_r, insel_nxt, gain_r, gain_nxt;
   logic [7:0] exc1_r, exc1_nxt, sysmon_r, sysmon_nxt;
   logic [7:0] status_r, status_nxt;
   afe_state_t state_r, state_nxt;
   logic [1:0] bbm_cnt_r, bbm_cnt_nxt;
   logic       rail_en;

   assign rail_en = exc1_r[EXC1_RAIL_BIT];

   always_comb begin
      insel_nxt   = insel_r;
      gain_nxt    = gain_r;
      exc1_nxt    = exc1_r;
      sysmon_nxt  = sysmon_r;
      state_nxt   = state_r;
      bbm_cnt_nxt = bbm_cnt_r;
      if (commit) begin
         if (wr_addr == ADDR_INSEL) begin
            insel_nxt = wr_data;
         end else if (wr_addr == ADDR_GAIN) begin
            gain_nxt = wr_data;
         end else if (wr_addr == ADDR_EXC1) begin
            exc1_nxt = wr_data;
         end else if (wr_addr == ADDR_SYSMON) begin
            sysmon_nxt = wr_data;
         end
      end
      // A new channel pair restarts the break even mid-interval
      if (commit && wr_addr == ADDR_INSEL && wr_data != insel_r) begin
         state_nxt   = ST_BREAK;
         bbm_cnt_nxt = BBM_CYCLES - 2'h1;
      end else begin
         case (state_r)
            ST_BREAK: begin
               if (bbm_cnt_r == 2'h0) begin
                  state_nxt = ST_CONNECT;
               end else begin
                  bbm_cnt_nxt = bbm_cnt_r - 2'h1;
               end
            end
            default: begin
               state_nxt = ST_CONNECT;
            end
         endcase
      end
      // Flags are live levels, forced low while detection is off
      status_nxt = RST_STATUS;
      if (rail_en) begin
         status_nxt[STAT_RAIL_LSB +: 4] = rail_s2_r;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         insel_r   <= RST_INSEL;
         gain_r    <= RST_GAIN;
         exc1_r    <= RST_EXC1;
         sysmon_r  <= RST_SYSMON;
         status_r  <= RST_STATUS;
         state_r   <= ST_CONNECT;
         bbm_cnt_r <= 2'h0;
      end else begin
         insel_r   <= insel_nxt;
         gain_r    <= gain_nxt;
         exc1_r    <= exc1_nxt;
         sysmon_r  <= sysmon_nxt;
         status_r  <= status_nxt;
         state_r   <= state_nxt;
         bbm_cnt_r <= bbm_cnt_nxt;
      end
   end

   // Read bank follows the registers only while no frame is open
   always_ff @(posedge clk) begin
      if (rst) begin
         sh_status_r <= RST_STATUS;
         sh_insel_r  <= RST_INSEL;
         sh_gain_r   <= RST_GAIN;
         sh_exc1_r   <= RST_EXC1;
         sh_sysmon_r <= RST_SYSMON;
      end else if (cs_s2_r) begin
         sh_status_r <= status_r;
         sh_insel_r  <= insel_r;
         sh_gain_r   <= gain_r;
         sh_exc1_r   <= exc1_r;
         sh_sysmon_r <= sysmon_r;
      end
   end

   // Analog controls, computed from next state so they align with it
   logic [NIN-1:0] pos_sw_nxt, neg_sw_nxt;
   logic [2:0]     mon_sel, gcode, again_nxt;
   logic [1:0]     dshift_nxt;
   logic           mid_nxt, temp_nxt, avdd_nxt, dvdd_nxt, burn_nxt;
   logic           amp_on_nxt, hbias_nxt;

   always_comb begin
      mon_sel    = sysmon_nxt[SYSMON_SEL_LSB +: 3];
      gcode      = gain_nxt[GAIN_CODE_LSB +: 3];
      pos_sw_nxt = '0;
      neg_sw_nxt = '0;
      mid_nxt    = 1'b0;
      temp_nxt   = 1'b0;
      avdd_nxt   = 1'b0;
      dvdd_nxt   = 1'b0;
      burn_nxt   = 1'b0;
      if (state_nxt == ST_BREAK) begin
         mid_nxt = 1'b1;
      end else if (mon_sel == MON_SHORT) begin
         mid_nxt = 1'b1;
      end else if (mon_sel == MON_TEMP) begin
         temp_nxt = 1'b1;
      end else if (mon_sel == MON_AVDD) begin
         avdd_nxt = 1'b1;
      end else if (mon_sel == MON_DVDD) begin
         dvdd_nxt = 1'b1;
      end else begin
         pos_sw_nxt = chan_onehot(insel_nxt[INSEL_P_LSB +: 4]);
         neg_sw_nxt = chan_onehot(insel_nxt[INSEL_N_LSB +: 4]);
         burn_nxt   = sysmon_nxt[SYSMON_BURN];
      end
      // Bypass only at gain 1; reserved enable codes keep it powered
      amp_on_nxt = (gain_nxt[GAIN_EN_LSB +: 2] != AMP_OFF) ||
                   (gcode != GAIN_CODE_1);
      again_nxt  = 3'h0;
      dshift_nxt = 2'h0;
      hbias_nxt  = 1'b0;
      if (amp_on_nxt && gcode > GAIN_CODE_32) begin
         again_nxt  = GAIN_CODE_32;
         dshift_nxt = 2'(gcode - GAIN_CODE_32);
         hbias_nxt  = 1'b1;
      end else if (amp_on_nxt) begin
         again_nxt = gcode;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pos_switch    <= chan_onehot(RST_INSEL[INSEL_P_LSB +: 4]);
         neg_switch    <= chan_onehot(RST_INSEL[INSEL_N_LSB +: 4]);
         mid_short     <= 1'b0;
         temp_sense_en <= 1'b0;
         avdd_mon_en   <= 1'b0;
         dvdd_mon_en   <= 1'b0;
         burnout_en    <= 1'b0;
         amp_power_en  <= 1'b0;
         amp_bypass    <= 1'b1;
         analog_gain   <= 3'h0;
         digital_shift <= 2'h0;
         amp_high_bias <= 1'b0;
      end else begin
         pos_switch    <= pos_sw_nxt;
         neg_switch    <= neg_sw_nxt;
         mid_short     <= mid_nxt;
         temp_sense_en <= temp_nxt;
         avdd_mon_en   <= avdd_nxt;
         dvdd_mon_en   <= dvdd_nxt;
         burnout_en    <= burn_nxt;
         amp_power_en  <= amp_on_nxt;
         amp_bypass    <= ~amp_on_nxt;
         analog_gain   <= again_nxt;
         digital_shift <= dshift_nxt;
         amp_high_bias <= hbias_nxt;
      end
   end

   // Checks on the system clock domain
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_break_then_make: assert property (
      commit && wr_addr == ADDR_INSEL && wr_data != insel_r |=>
      (mid_short && pos_switch == '0 && neg_switch == '0)[*2]
      ##1 (state_r == ST_CONNECT))
      else $error("break-before-make interval wrong");
   a_channel_route: assert property (
      state_r == ST_CONNECT && sysmon_r[SYSMON_SEL_LSB +: 3] == MON_NONE
      |-> pos_switch == chan_onehot(insel_r[INSEL_P_LSB +: 4]) &&
          neg_switch == chan_onehot(insel_r[INSEL_N_LSB +: 4]))
      else $error("input switches do not follow the channel fields");
   a_common_input: assert property (
      state_r == ST_CONNECT && sysmon_r[SYSMON_SEL_LSB +: 3] == MON_NONE &&
      insel_r[INSEL_N_LSB +: 4] == CH_COMMON |-> neg_switch[CH_COMMON])
      else $error("common input not connected");
   a_offset_short: assert property (
      sysmon_r[SYSMON_SEL_LSB +: 3] == MON_SHORT |->
      mid_short && pos_switch == '0 && neg_switch == '0)
      else $error("offset monitor does not short inputs");
   a_monitor_sel: assert property (
      state_r == ST_CONNECT |->
      avdd_mon_en == (sysmon_r[SYSMON_SEL_LSB +: 3] == MON_AVDD) &&
      dvdd_mon_en == (sysmon_r[SYSMON_SEL_LSB +: 3] == MON_DVDD) &&
      temp_sense_en == (sysmon_r[SYSMON_SEL_LSB +: 3] == MON_TEMP))
      else $error("monitor enables do not match selection");
   a_gain_split: assert property (
      amp_power_en && gain_r[GAIN_CODE_LSB +: 3] > GAIN_CODE_32 |->
      analog_gain == GAIN_CODE_32 && amp_high_bias &&
      digital_shift == 2'(gain_r[GAIN_CODE_LSB +: 3] - GAIN_CODE_32))
      else $error("high gain split wrong");
   a_gain_direct: assert property (
      amp_power_en && gain_r[GAIN_CODE_LSB +: 3] <= GAIN_CODE_32 |->
      analog_gain == gain_r[GAIN_CODE_LSB +: 3] && digital_shift == 2'h0)
      else $error("direct gain wrong");
   a_bypass_gain1: assert property (
      amp_bypass |-> gain_r[GAIN_CODE_LSB +: 3] == GAIN_CODE_1 &&
      gain_r[GAIN_EN_LSB +: 2] == AMP_OFF && !amp_power_en)
      else $error("bypass outside gain 1 with field 00");
   a_amp_enable: assert property (
      gain_r[GAIN_EN_LSB +: 2] == AMP_ON |-> amp_power_en && !amp_bypass)
      else $error("amplifier not enabled");
   a_rail_off: assert property (
      !rail_en |=> status_r[STAT_RAIL_LSB +: 4] == 4'h0)
      else $error("rail flags set with detection off");
   a_rail_follow: assert property (
      rail_en && rail_s2_r != 4'h0 |=>
      status_r[STAT_RAIL_LSB +: 4] == $past(rail_s2_r))
      else $error("rail flags do not follow comparators");
   a_write_commit: assert property (
      commit && wr_addr == ADDR_GAIN |=> gain_r == $past(wr_data))
      else $error("gain register write lost");

   c_channel_change: cover property (
      commit && wr_addr == ADDR_INSEL && wr_data != insel_r);
   c_high_gain: cover property (amp_high_bias);
   c_bypass: cover property (amp_bypass ##1 amp_power_en);
   c_rail_flag: cover property (status_r[STAT_RAIL_LSB +: 4] != 4'h0);
endmodule : afe_front_end_ctrl
`default_nettype wire

// ===== verilog/afe_pkg.sv
// Shared constants for the analog front-end control block
package afe_pkg;
   // Register offsets seen over the serial link
   localparam logic [4:0] ADDR_STATUS = 5'h01;
   localparam logic [4:0] ADDR_INSEL  = 5'h02;
   localparam logic [4:0] ADDR_GAIN   = 5'h03;
   localparam logic [4:0] ADDR_EXC1   = 5'h06;
   localparam logic [4:0] ADDR_SYSMON = 5'h09;

   // Serial command byte: opcode in [7:5], register offset in [4:0]
   localparam logic [2:0] OP_READ  = 3'h1;
   localparam logic [2:0] OP_WRITE = 3'h2;

   // Field positions
   localparam int INSEL_P_LSB    = 4;
   localparam int INSEL_N_LSB    = 0;
   localparam int GAIN_CODE_LSB  = 0;
   localparam int GAIN_EN_LSB    = 3;
   localparam int EXC1_RAIL_BIT  = 7;
   localparam int SYSMON_SEL_LSB = 0;
   localparam int SYSMON_BURN    = 3;
   localparam int STAT_RAIL_LSB  = 2;

   // Reset values
   localparam logic [7:0] RST_INSEL  = 8'h01;
   localparam logic [7:0] RST_GAIN   = 8'h00;
   localparam logic [7:0] RST_EXC1   = 8'h00;
   localparam logic [7:0] RST_SYSMON = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h00;

   // Channel and monitor codes
   localparam int         NUM_INPUTS = 13;
   localparam logic [3:0] CH_COMMON  = 4'hC;
   localparam logic [2:0] MON_NONE   = 3'h0;
   localparam logic [2:0] MON_SHORT  = 3'h1;
   localparam logic [2:0] MON_TEMP   = 3'h2;
   localparam logic [2:0] MON_AVDD   = 3'h3;
   localparam logic [2:0] MON_DVDD   = 3'h4;

   // Amplifier enable field and gain codes
   localparam logic [1:0] AMP_OFF     = 2'h0;
   localparam logic [1:0] AMP_ON      = 2'h1;
   localparam logic [2:0] GAIN_CODE_1  = 3'h0;
   localparam logic [2:0] GAIN_CODE_32 = 3'h5;

   // Break-before-make: two system clock periods; clk is the system clock
   localparam int         BBM_TCLK     = 2;
   localparam int         CLK_PER_TCLK = 1;
   localparam logic [1:0] BBM_CYCLES   = 2'(BBM_TCLK * CLK_PER_TCLK);

   // Mux sequencing states
   typedef enum logic [0:0] {
      ST_CONNECT = 1'b0,
      ST_BREAK   = 1'b1
   } afe_state_t;
endpackage : afe_pkg

// ===== verilog/afe_spi_link.sv
// Serial link end of the front-end control, clocked by the host's sclk
`timescale 1ns/1ps
`default_nettype none
module afe_spi_link
   import afe_pkg::*;
(
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       din,
   output logic            dout,
   output logic            dout_oe_n,
   input  wire logic [7:0] rd_status,
   input  wire logic [7:0] rd_insel,
   input  wire logic [7:0] rd_gain,
   input  wire logic [7:0] rd_exc1,
   input  wire logic [7:0] rd_sysmon,
   output logic            wr_valid,
   output logic [4:0]      wr_addr,
   output logic [7:0]      wr_data
);
   logic [3:0] bit_cnt_r, bit_cnt_nxt;
   logic [7:0] in_sh_r, in_sh_nxt;
   logic [7:0] cmd_r, cmd_nxt;
   logic       wr_valid_r, wr_valid_nxt;
   logic [4:0] wr_addr_r, wr_addr_nxt;
   logic [7:0] wr_data_r, wr_data_nxt;
   logic       dout_r, dout_nxt;
   logic [7:0] out_sh_r, out_sh_nxt;
   logic [7:0] rd_byte;

   // Read mux; the bank is frozen by the core while cs_n is low
   always_comb begin
      if (cmd_r[4:0] == ADDR_STATUS) begin
         rd_byte = rd_status;
      end else if (cmd_r[4:0] == ADDR_INSEL) begin
         rd_byte = rd_insel;
      end else if (cmd_r[4:0] == ADDR_GAIN) begin
         rd_byte = rd_gain;
      end else if (cmd_r[4:0] == ADDR_EXC1) begin
         rd_byte = rd_exc1;
      end else if (cmd_r[4:0] == ADDR_SYSMON) begin
         rd_byte = rd_sysmon;
      end else begin
         rd_byte = 8'h00;               // Unmapped offsets read as zero
      end
   end

   // Falling edge: sample din, count bits, latch command and write data
   always_comb begin
      bit_cnt_nxt  = (bit_cnt_r == 4'hF) ? bit_cnt_r : bit_cnt_r + 4'h1;
      in_sh_nxt    = {in_sh_r[6:0], din};
      cmd_nxt      = (bit_cnt_r == 4'h7) ? in_sh_nxt : cmd_r;
      wr_valid_nxt = (bit_cnt_r == 4'h0) ? 1'b0 : wr_valid_r;
      wr_addr_nxt  = wr_addr_r;
      wr_data_nxt  = wr_data_r;
      if (bit_cnt_r == 4'hF && cmd_r[7:5] == OP_WRITE) begin
         wr_valid_nxt = 1'b1;
         wr_addr_nxt  = cmd_r[4:0];
         wr_data_nxt  = in_sh_nxt;
      end
   end

   // Frame counters restart whenever cs_n is high
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt_r <= 4'h0;
         in_sh_r   <= 8'h00;
         cmd_r     <= 8'h00;
      end else begin
         bit_cnt_r <= bit_cnt_nxt;
         in_sh_r   <= in_sh_nxt;
         cmd_r     <= cmd_nxt;
      end
   end

   // Write holding word outlives the frame so the core can take it
   always_ff @(negedge sclk) begin
      wr_valid_r <= wr_valid_nxt;
      wr_addr_r  <= wr_addr_nxt;
      wr_data_r  <= wr_data_nxt;
   end

   // Rising edge: shift read data out, MSB first, in the second byte
   always_comb begin
      dout_nxt   = 1'b0;
      out_sh_nxt = 8'h00;
      if (bit_cnt_r == 4'h8 && cmd_r[7:5] == OP_READ) begin
         dout_nxt   = rd_byte[7];
         out_sh_nxt = {rd_byte[6:0], 1'b0};
      end else if (bit_cnt_r > 4'h8) begin
         dout_nxt   = out_sh_r[7];
         out_sh_nxt = {out_sh_r[6:0], 1'b0};
      end
   end

   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         dout_r   <= 1'b0;
         out_sh_r <= 8'h00;
      end else begin
         dout_r   <= dout_nxt;
         out_sh_r <= out_sh_nxt;
      end
   end

   assign dout      = dout_r;
   assign dout_oe_n = cs_n;             // Released outside a frame
   assign wr_valid  = wr_valid_r;
   assign wr_addr   = wr_addr_r;
   assign wr_data   = wr_data_r;
endmodule : afe_spi_link
`default_nettype wire
